// >>> include/plc_io_pkg.sv
// Constants, register map and enumerations for the controller relay and input mapper.
// Assumes a single 100 MHz clock and an APB register bus with 32-bit data.
package plc_io_pkg;
	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYCLES_PER_MS_DFLT = MS_NS / CLK_PERIOD_NS;
	localparam int RATE_W = 7;
	localparam logic [RATE_W-1:0] RATE_MIN_MS = 7'h0a;
	localparam logic [RATE_W-1:0] RATE_MAX_MS = 7'h64;
	localparam int VENT_W = 16;
	// ********************************
	// Sizes and register map
	// ********************************
	localparam int LOC_W = 3;
	localparam int SEL_W = 4;
	localparam int N_RELAY = 4;
	localparam int N_IN = 3;
	localparam int SIG_CNT = 15;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RELAY_SEL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_INPUT_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_VENT_DELAY = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam int CTRL_LOC_LSB = 0;
	localparam int CTRL_RATE_LSB = 8;
	localparam int RELAY_SEL_STRIDE = 8;
	localparam int IN_SEL_STRIDE = 4;
	localparam int STAT_COIL_LSB = 0;
	localparam int STAT_IN_LSB = 4;
	localparam int STAT_LOCK_BIT = 8;
	localparam int STAT_EXTCAL_BIT = 9;
	localparam int STAT_VENT_LSB = 10;
	localparam logic [31:0] RELAY_SEL_RST = 32'h08080808;
	localparam logic [VENT_W-1:0] VENT_RST = 16'h03e8;
	// ********************************
	// Enumerations
	// ********************************
	typedef enum logic [3:0] {
		SIG_TRIG1 = 4'h0, SIG_ZERO = 4'h1, SIG_READY = 4'h2, SIG_CAL_RUN = 4'h3,
		SIG_CAL_REQ = 4'h4, SIG_FAIL = 4'h5, SIG_WARN = 4'h6, SIG_GAS_BALLAST = 4'h7,
		SIG_OPEN = 4'h8, SIG_CLOSE = 4'h9, SIG_CHART_INVALID = 4'ha, SIG_PUMP_DOWN = 4'hb,
		SIG_STANDBY = 4'hc, SIG_VENTED = 4'hd, SIG_EMISSION = 4'he
	} relay_sig_t;
	typedef enum logic [3:0] {
		FN_NONE = 4'h0, FN_ZERO = 4'h1, FN_START = 4'h2, FN_STOP = 4'h3, FN_PURGE = 4'h4,
		FN_CLEAR = 4'h5, FN_CAL = 4'h6, FN_CAL_INT = 4'h7, FN_CAL_EXT = 4'h8
	} in_func_t;
	typedef enum logic [2:0] {
		LOC_LOCAL = 3'h0, LOC_PLC = 3'h1, LOC_RS232 = 3'h2, LOC_ALL = 3'h3,
		LOC_PANEL_PLUS_CONTROLLER_LOCATION = 3'h4, LOC_LOCAL_RS232 = 3'h5
	} loc_t;
	typedef enum logic [1:0] {
		VENT_IDLE = 2'b00, VENT_HOLD = 2'b01, VENT_DONE = 2'b11
	} vent_state_t;
	// ********************************
	// Functions
	// ********************************
	function automatic logic loc_accepts(input logic [LOC_W-1:0] loc);
		return (loc == LOC_PLC) || (loc == LOC_ALL) || (loc == LOC_PANEL_PLUS_CONTROLLER_LOCATION);
	endfunction
	function automatic logic [RATE_W-1:0] clamp_rate(input logic [RATE_W-1:0] r);
		if (r < RATE_MIN_MS)
			return RATE_MIN_MS;
		if (r > RATE_MAX_MS)
			return RATE_MAX_MS;
		return r;
	endfunction
	function automatic logic [SEL_W-1:0] field4(input logic [31:0] w, input int lsb);
		return w[lsb +: SEL_W];
	endfunction
endpackage

// >>> verilog/relay_selector.sv
// One relay output: picks one closed-sense signal and drives the coil from a flop.
// Assumes the sense vector is already in closed-is-one form.
`timescale 1ns/10ps
module relay_selector
	import plc_io_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [SIG_CNT-1:0] sense_closed,
	input wire relay_sig_t sel,
	output logic coil_r
);
	logic coil_nxt;

	// Codes beyond the table leave the coil released, so the normally-open contact reads open.
	always_comb
	begin
		coil_nxt = 1'b0;
		if (int'(sel) < SIG_CNT)
			coil_nxt = sense_closed[sel];
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			coil_r <= 1'b0;
		else
			coil_r <= coil_nxt;
	end
endmodule // relay_selector

// >>> verilog/input_sampler.sv
// Millisecond prescaler, sample-interval timer and edge detector for the control inputs.
// Assumes the inputs are synchronous to ref_clk and the rate is already clamped.
`timescale 1ns/10ps
module input_sampler
	import plc_io_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [RATE_W-1:0] rate_ms,
	input wire logic [N_IN-1:0] pins,
	output logic ms_tick_r,
	output logic [N_IN-1:0] level_r,
	output logic [N_IN-1:0] rise_r,
	output logic [N_IN-1:0] fall_r
);
	localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);
	logic [PRE_W-1:0] pre_r;
	logic [RATE_W-1:0] ivl_r;
	logic sample;

	always_ff @(posedge ref_clk)
	begin
		if (rst || pre_r == PRE_W'(CYCLES_PER_MS - 1))
			pre_r <= '0;
		else
			pre_r <= pre_r + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ms_tick_r <= 1'b0;
		else
			ms_tick_r <= (pre_r == PRE_W'(CYCLES_PER_MS - 1));
	end

	// A shortened rate takes effect at once; the running interval is cut, never stretched.
	assign sample = ms_tick_r && (ivl_r >= rate_ms - 1'b1);

	always_ff @(posedge ref_clk)
	begin
		if (rst || sample)
			ivl_r <= '0;
		else if (ms_tick_r)
			ivl_r <= ivl_r + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			level_r <= '0;
			rise_r <= '0;
			fall_r <= '0;
		end
		else
		begin
			rise_r <= sample ? (pins & ~level_r) : '0;
			fall_r <= sample ? (~pins & level_r) : '0;
			if (sample)
				level_r <= pins;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_edge_level: assert property (
		(|rise_r) |-> ((rise_r & level_r & ~$past(level_r)) == rise_r))
		else $error("rise pulse without a new high sample");
	a_tick_spacing: assert property (
		ms_tick_r |=> !ms_tick_r)
		else $error("millisecond tick lasted more than one cycle");
endmodule // input_sampler

// >>> verilog/plc_relay_io_mapper.sv
// Top of the controller relay and input mapper: APB registers, relay mapping, input decode.
// Assumes machine state arrives as synchronous levels and events leave as one-cycle pulses.
`timescale 1ns/10ps
module plc_relay_io_mapper
	import plc_io_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [N_IN-1:0] plc_in,
	input wire logic leak_over_trig1,
	input wire logic measuring,
	input wire logic zero_running,
	input wire logic emission_on,
	input wire logic error_present,
	input wire logic cal_running,
	input wire logic cal_request,
	input wire logic error_shown,
	input wire logic warning_shown,
	input wire logic gas_ballast_on,
	input wire logic recorder_invalid,
	input wire logic recorder_lr_mode,
	input wire logic evacuating,
	input wire logic standby_mode,
	input wire logic vent_mode,
	output logic [N_RELAY-1:0] relay_coil,
	output logic local_lockout,
	output logic zero_on_r,
	output logic zero_off_r,
	output logic start_r,
	output logic stop_r,
	output logic vent_r,
	output logic purge_on_r,
	output logic purge_off_r,
	output logic clear_err_r,
	output logic cal_int_r,
	output logic cal_ext_r,
	output logic cal_confirm_r
);
	// ********************************
	// Registers and bus slave
	// ********************************
	logic [LOC_W-1:0] loc_r;
	logic [RATE_W-1:0] rate_r;
	logic [31:0] relay_sel_r, in_sel_r, prdata_r, rd_nxt;
	logic [VENT_W-1:0] vent_delay_r, vent_cnt_r;
	logic setup_ph, wr_ph, accept, ext_cal_r, ms_tick;
	vent_state_t vent_st_r, vent_st_nxt;
	logic [N_IN-1:0] level, rise, fall;
	logic [SIG_CNT-1:0] sense;
	logic ev_zero_on, ev_zero_off, ev_start, ev_stop, ev_purge_on, ev_purge_off;
	logic ev_clear, ev_cal_int, ev_cal_ext, cal_rise, confirm_fall, stop_lvl;
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_RELAY_SEL) || (a == OFS_INPUT_SEL) ||
			(a == OFS_VENT_DELAY) || (a == OFS_STATUS);
	endfunction
	assign setup_ph = psel && !penable;
	assign wr_ph = psel && penable && pwrite && addr_mapped(paddr);
	// Every access completes at the first access cycle, so no wait states exist.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_mapped(paddr);
	assign prdata = prdata_r;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			loc_r <= LOC_LOCAL;
			rate_r <= RATE_MIN_MS;
		end
		else if (wr_ph && paddr == OFS_CTRL)
		begin
			loc_r <= pwdata[CTRL_LOC_LSB +: LOC_W];
			rate_r <= clamp_rate(pwdata[CTRL_RATE_LSB +: RATE_W]);
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			relay_sel_r <= RELAY_SEL_RST;
		else if (wr_ph && paddr == OFS_RELAY_SEL)
			relay_sel_r <= pwdata;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			in_sel_r <= '0;
		else if (wr_ph && paddr == OFS_INPUT_SEL)
			in_sel_r <= pwdata;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			vent_delay_r <= VENT_RST;
		else if (wr_ph && paddr == OFS_VENT_DELAY)
			vent_delay_r <= pwdata[VENT_W-1:0];
	end
	always_comb
	begin
		rd_nxt = '0;
		case (paddr)
			OFS_CTRL:
			begin
				rd_nxt[CTRL_LOC_LSB +: LOC_W] = loc_r;
				rd_nxt[CTRL_RATE_LSB +: RATE_W] = rate_r;
			end
			OFS_RELAY_SEL: rd_nxt = relay_sel_r;
			OFS_INPUT_SEL: rd_nxt = in_sel_r;
			OFS_VENT_DELAY: rd_nxt[VENT_W-1:0] = vent_delay_r;
			OFS_STATUS:
			begin
				rd_nxt[STAT_COIL_LSB +: N_RELAY] = relay_coil;
				rd_nxt[STAT_IN_LSB +: N_IN] = level;
				rd_nxt[STAT_LOCK_BIT] = local_lockout;
				rd_nxt[STAT_EXTCAL_BIT] = ext_cal_r;
				rd_nxt[STAT_VENT_LSB +: $bits(vent_state_t)] = vent_st_r;
			end
			default: rd_nxt = '0;
		endcase
	end
	// Read data is captured in the setup cycle so it stands from a flop during the access cycle.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			prdata_r <= '0;
		else if (setup_ph)
			prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
	end
	// ********************************
	// Relay outputs
	// ********************************
	always_comb
	begin
		sense = '0;
		sense[SIG_TRIG1] = measuring && !leak_over_trig1;
		sense[SIG_ZERO] = zero_running;
		sense[SIG_READY] = emission_on && !error_present;
		sense[SIG_CAL_RUN] = cal_running;
		sense[SIG_CAL_REQ] = !cal_request;
		sense[SIG_FAIL] = !error_shown;
		sense[SIG_WARN] = !warning_shown;
		sense[SIG_GAS_BALLAST] = gas_ballast_on;
		sense[SIG_OPEN] = 1'b0;
		sense[SIG_CLOSE] = 1'b1;
		sense[SIG_CHART_INVALID] = recorder_invalid && recorder_lr_mode;
		sense[SIG_PUMP_DOWN] = !evacuating;
		sense[SIG_STANDBY] = !(standby_mode || vent_mode);
		sense[SIG_VENTED] = !vent_mode;
		sense[SIG_EMISSION] = !emission_on;
	end
	for (genvar g = 0; g < N_RELAY; g++)
	begin : g_relay
		relay_selector u_sel (
			.ref_clk(ref_clk),
			.rst(rst),
			.sense_closed(sense),
			.sel(relay_sig_t'(field4(relay_sel_r, g * RELAY_SEL_STRIDE))),
			.coil_r(relay_coil[g])
		);
	end
	// ********************************
	// Control inputs
	// ********************************
	input_sampler #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_samp (
		.ref_clk(ref_clk),
		.rst(rst),
		.rate_ms(rate_r),
		.pins(plc_in),
		.ms_tick_r(ms_tick),
		.level_r(level),
		.rise_r(rise),
		.fall_r(fall)
	);
	assign accept = loc_accepts(loc_r);
	assign local_lockout = (loc_r == LOC_PLC);
	// Several inputs may carry the same function; their edges are merged into one pulse.
	always_comb
	begin
		{ev_zero_on, ev_zero_off, ev_start, ev_stop, ev_purge_on, ev_purge_off} = '0;
		{ev_clear, ev_cal_int, ev_cal_ext, cal_rise, confirm_fall, stop_lvl} = '0;
		for (int i = 0; i < N_IN; i++)
		begin
			case (in_func_t'(field4(in_sel_r, i * IN_SEL_STRIDE)))
				FN_ZERO:
				begin
					ev_zero_on |= rise[i];
					ev_zero_off |= fall[i];
				end
				FN_START: ev_start |= rise[i];
				FN_STOP:
				begin
					ev_stop |= rise[i];
					stop_lvl |= level[i];
				end
				FN_PURGE:
				begin
					ev_purge_on |= rise[i];
					ev_purge_off |= fall[i];
				end
				FN_CLEAR: ev_clear |= rise[i];
				FN_CAL:
				begin
					cal_rise |= rise[i];
					confirm_fall |= fall[i];
				end
				FN_CAL_INT: ev_cal_int |= rise[i];
				FN_CAL_EXT:
				begin
					ev_cal_ext |= rise[i];
					confirm_fall |= fall[i];
				end
				default: ;
			endcase
		end
		ev_cal_int |= cal_rise && standby_mode;
		ev_cal_ext |= cal_rise && !standby_mode && measuring;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			{zero_on_r, zero_off_r, start_r, stop_r, purge_on_r} <= '0;
			{purge_off_r, clear_err_r, cal_int_r, cal_ext_r, cal_confirm_r} <= '0;
		end
		else
		begin
			zero_on_r <= ev_zero_on && accept;
			zero_off_r <= ev_zero_off && accept;
			start_r <= ev_start && accept;
			stop_r <= ev_stop && accept;
			purge_on_r <= ev_purge_on && accept;
			purge_off_r <= ev_purge_off && accept;
			clear_err_r <= ev_clear && accept;
			cal_int_r <= ev_cal_int && accept;
			cal_ext_r <= ev_cal_ext && accept;
			cal_confirm_r <= confirm_fall && ext_cal_r && accept;
		end
	end
	// Confirmation is only meaningful after an external run was started; a new start wins.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ext_cal_r <= 1'b0;
		else if (ev_cal_ext && accept)
			ext_cal_r <= 1'b1;
		else if (confirm_fall && accept)
			ext_cal_r <= 1'b0;
	end
	// ********************************
	// Stop hold and vent
	// ********************************
	always_comb
	begin
		vent_st_nxt = vent_st_r;
		case (vent_st_r)
			VENT_IDLE:
				if (ev_stop && accept)
					vent_st_nxt = VENT_HOLD;
			VENT_HOLD:
				if (!(stop_lvl && accept))
					vent_st_nxt = VENT_IDLE;
				else if (ms_tick && vent_cnt_r >= vent_delay_r)
					vent_st_nxt = VENT_DONE;
			VENT_DONE:
				if (!(stop_lvl && accept))
					vent_st_nxt = VENT_IDLE;
			default: vent_st_nxt = VENT_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			vent_st_r <= VENT_IDLE;
		else
			vent_st_r <= vent_st_nxt;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst || vent_st_r != VENT_HOLD)
			vent_cnt_r <= '0;
		else if (ms_tick && vent_cnt_r != {VENT_W{1'b1}})
			vent_cnt_r <= vent_cnt_r + 1'b1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			vent_r <= 1'b0;
		else
			vent_r <= (vent_st_r == VENT_HOLD) && (vent_st_nxt == VENT_DONE);
	end
	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_locked_start: assert property (
		start_r |-> $past(accept))
		else $error("start pulse while control location forbids inputs");
	a_ready_coil: assert property (
		(relay_sel_r[SEL_W-1:0] == SIG_READY && $past(relay_sel_r[SEL_W-1:0]) == SIG_READY)
		|-> relay_coil[0] == $past(emission_on && !error_present))
		else $error("ready contact does not follow emission and error");
	a_trig1_coil: assert property (
		(relay_sel_r[SEL_W-1:0] == SIG_TRIG1 && $past(relay_sel_r[SEL_W-1:0]) == SIG_TRIG1)
		|-> relay_coil[0] == $past(measuring && !leak_over_trig1))
		else $error("trigger one contact wrong");
	a_rate_range: assert property (
		rate_r >= RATE_MIN_MS && rate_r <= RATE_MAX_MS)
		else $error("sample rate out of range");
	a_ext_cal_mode: assert property (
		(cal_ext_r && $past(cal_rise) && !$past(ev_cal_ext && !cal_rise))
		|-> $past(!standby_mode && measuring))
		else $error("external calibration outside measuring");
	a_vent_delay: assert property (
		vent_r |-> ($past(vent_cnt_r) >= $past(vent_delay_r) && $past(stop_lvl)))
		else $error("vent before the configured delay");
	a_lockout_plc: assert property (
		(wr_ph && paddr == OFS_CTRL) |=> local_lockout == ($past(pwdata[LOC_W-1:0]) == LOC_PLC))
		else $error("lockout does not follow control location");
	a_status_read: assert property (
		(psel && penable && !pwrite && paddr == OFS_STATUS && $past(setup_ph))
		|-> prdata[N_RELAY-1:0] == $past(relay_coil))
		else $error("status read does not show relay coils");
	a_confirm_ext: assert property (
		cal_confirm_r |-> $past(ext_cal_r) ##1 !ext_cal_r || cal_ext_r)
		else $error("confirm without pending external calibration");
	c_start: cover property (start_r);
	c_vent: cover property (stop_r ##[1:1000] vent_r);
	c_ext_cal: cover property (cal_ext_r ##[1:1000] cal_confirm_r);
	c_cal_int: cover property (cal_int_r);
endmodule // plc_relay_io_mapper

// >>> tb/plc_model.sv
// Controller model: drives the three control inputs and reads the relays as contact pairs.
// Assumes the bench calls its task from the ref_clk domain.
`timescale 1ns/10ps
module plc_model
	import plc_io_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [N_RELAY-1:0] relay_coil,
	output logic [N_IN-1:0] plc_in,
	output logic [N_RELAY-1:0] no_closed,
	output logic [N_RELAY-1:0] nc_closed
);
	initial plc_in = '0;
	// Each relay is a changeover, so exactly one contact touches the centre at a time.
	assign no_closed = relay_coil;
	assign nc_closed = ~relay_coil;
	// The control lines are changed only by this task, at the next ref_clk edge after the call.
	task automatic set_pin(input int i, input logic v);
		@(posedge ref_clk);
		plc_in[i] <= v;
	endtask
endmodule // plc_model

// >>> tb/testbench.sv
// Bench for the relay and input mapper: registers, relay mapping and input decode.
// Assumes the controller model on the inputs; machine state is driven from here.
`timescale 1ns/10ps
module testbench
	import plc_io_pkg::*;
;
	localparam int CPM = 10;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, local_lockout;
	logic [N_IN-1:0] plc_in;
	logic [14:0] st = '0;
	logic [N_RELAY-1:0] relay_coil, no_closed, nc_closed;
	wire [10:0] ev;
	int cnt [11];
	int cyc = 0;
	int errors = 0;
	int num_checks = 0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		cyc <= cyc + 1;
	// Pulses are counted mid-cycle, where the registered outputs have settled.
	always @(negedge ref_clk)
		for (int i = 0; i < 11; i++)
			if (ev[i] === 1'b1)
				cnt[i] = cnt[i] + 1;
	plc_relay_io_mapper #(.CYCLES_PER_MS(CPM)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .plc_in(plc_in),
		.leak_over_trig1(st[0]), .measuring(st[1]), .zero_running(st[2]),
		.emission_on(st[3]), .error_present(st[4]), .cal_running(st[5]),
		.cal_request(st[6]), .error_shown(st[7]), .warning_shown(st[8]),
		.gas_ballast_on(st[9]), .recorder_invalid(st[10]), .recorder_lr_mode(st[11]),
		.evacuating(st[12]), .standby_mode(st[13]), .vent_mode(st[14]),
		.relay_coil(relay_coil), .local_lockout(local_lockout), .zero_on_r(ev[0]),
		.zero_off_r(ev[1]), .start_r(ev[2]), .stop_r(ev[3]), .vent_r(ev[4]),
		.purge_on_r(ev[5]), .purge_off_r(ev[6]), .clear_err_r(ev[7]), .cal_int_r(ev[8]),
		.cal_ext_r(ev[9]), .cal_confirm_r(ev[10]));
	plc_model i_plc (.ref_clk(ref_clk), .relay_coil(relay_coil), .plc_in(plc_in),
		.no_closed(no_closed), .nc_closed(nc_closed));
	// ********************************
	// Shared tasks
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp, "read data");
		check({31'h0, e}, {31'h0, ee}, "slave error");
	endtask
	task automatic set_ctrl(input logic [2:0] loc, input logic [6:0] rate);
		wr(OFS_CTRL, {17'h0, rate, 5'h0, loc});
	endtask
	task automatic set_fn(input int pin, input in_func_t fn);
		wr(OFS_INPUT_SEL, {28'h0, fn} << (IN_SEL_STRIDE * pin));
	endtask
	// A pulse seen twice for one edge reads as a wrong mask bit.
	task automatic edge_chk(input int pin, input logic v, input logic [10:0] exp);
		logic [10:0] got;
		for (int i = 0; i < 11; i++)
			cnt[i] = 0;
		i_plc.set_pin(pin, v);
		repeat (250) @(posedge ref_clk);
		for (int i = 0; i < 11; i++)
			got[i] = (cnt[i] == 1) ? 1'b1 : ((cnt[i] == 0) ? 1'b0 : ~exp[i]);
		check({21'h0, got}, {21'h0, exp}, "event pulses");
	endtask
	task automatic wait_ev(input int idx, output int t);
		int n;
		n = 0;
		while (ev[idx] !== 1'b1 && n < 3000)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (ev[idx] !== 1'b1)
		begin
			errors++;
			test_done();
		end
		t = cyc;
	endtask
	function automatic logic sense(input int c, input logic [14:0] s);
		case (c)
			0: return s[1] & ~s[0];
			1: return s[2];
			2: return s[3] & ~s[4];
			3: return s[5];
			4: return ~s[6];
			5: return ~s[7];
			6: return ~s[8];
			7: return s[9];
			9: return 1'b1;
			10: return s[10] & s[11];
			11: return ~s[12];
			12: return ~(s[13] | s[14]);
			13: return ~s[14];
			14: return ~s[3];
			default: return 1'b0;
		endcase
	endfunction
	// ********************************
	// Scenarios
	// ********************************
	task automatic reg_test();
		rd_chk(OFS_CTRL, 32'h00000a00, 1'b0);
		rd_chk(OFS_RELAY_SEL, RELAY_SEL_RST, 1'b0);
		rd_chk(OFS_INPUT_SEL, 32'h0, 1'b0);
		rd_chk(OFS_VENT_DELAY, {16'h0, VENT_RST}, 1'b0);
		rd_chk(OFS_STATUS, 32'h0, 1'b0);
		rd_chk(8'h20, 32'h0, 1'b1);
		$display("register test done");
	endtask
	task automatic relay_test();
		logic [14:0] pats [6] = '{15'h0000, 15'h7fff, 15'h0002, 15'h2aaa, 15'h5555, 15'h0808};
		logic [31:0] w;
		logic [3:0] exp;
		for (int c = 0; c < 16; c++)
		begin
			for (int n = 0; n < 4; n++)
				w[8*n +: 8] = 8'((c + n) % 16);
			wr(OFS_RELAY_SEL, w);
			for (int p = 0; p < 6; p++)
			begin
				@(posedge ref_clk);
				st <= pats[p];
				repeat (3) @(posedge ref_clk);
				@(negedge ref_clk);
				for (int n = 0; n < 4; n++)
					exp[n] = sense((c + n) % 16, pats[p]);
				check({28'h0, relay_coil}, {28'h0, exp}, "coils");
				check({28'h0, no_closed}, {28'h0, exp}, "make");
				check({28'h0, nc_closed}, {28'h0, ~exp}, "break");
			end
		end
		@(posedge ref_clk);
		st <= '0;
		$display("relay test done");
	endtask
	task automatic loc_test();
		logic acc;
		set_fn(0, FN_START);
		for (int l = 0; l < 6; l++)
		begin
			acc = (l == 1) || (l == 3) || (l == 4);
			set_ctrl(3'(l), 7'h0a);
			@(negedge ref_clk);
			check({31'h0, local_lockout}, {31'h0, l == 1}, "lockout");
			edge_chk(0, 1'b1, acc ? 11'h004 : 11'h000);
			edge_chk(0, 1'b0, 11'h000);
		end
		$display("location test done");
	endtask
	task automatic func_test();
		set_ctrl(3'h1, 7'h0a);
		set_fn(0, FN_CLEAR);
		edge_chk(0, 1'b1, 11'h080);
		edge_chk(0, 1'b0, 11'h000);
		set_fn(1, FN_ZERO);
		edge_chk(1, 1'b1, 11'h001);
		edge_chk(1, 1'b0, 11'h002);
		set_fn(2, FN_PURGE);
		edge_chk(2, 1'b1, 11'h020);
		edge_chk(2, 1'b0, 11'h040);
		set_fn(0, FN_NONE);
		edge_chk(0, 1'b1, 11'h000);
		edge_chk(0, 1'b0, 11'h000);
		wr(OFS_VENT_DELAY, 32'h3);
		set_fn(0, FN_STOP);
		edge_chk(0, 1'b1, 11'h018);
		edge_chk(0, 1'b0, 11'h000);
		wr(OFS_VENT_DELAY, 32'hffff);
		edge_chk(0, 1'b1, 11'h008);
		edge_chk(0, 1'b0, 11'h000);
		$display("function test done");
	endtask
	task automatic cal_test();
		set_fn(2, FN_CAL);
		st <= 15'h2000;
		edge_chk(2, 1'b1, 11'h100);
		edge_chk(2, 1'b0, 11'h000);
		st <= 15'h0002;
		edge_chk(2, 1'b1, 11'h200);
		edge_chk(2, 1'b0, 11'h400);
		set_fn(2, FN_CAL_INT);
		edge_chk(2, 1'b1, 11'h100);
		edge_chk(2, 1'b0, 11'h000);
		set_fn(2, FN_CAL_EXT);
		st <= 15'h2000;
		edge_chk(2, 1'b1, 11'h200);
		edge_chk(2, 1'b0, 11'h400);
		st <= '0;
		$display("calibration test done");
	endtask
	task automatic rate_test(input logic [6:0] rate, input logic [6:0] eff);
		int t1, t2;
		set_ctrl(3'h1, rate);
		rd_chk(OFS_CTRL, {17'h0, eff, 5'h0, 3'h1}, 1'b0);
		set_fn(1, FN_ZERO);
		i_plc.set_pin(1, 1'b1);
		wait_ev(0, t1);
		i_plc.set_pin(1, 1'b0);
		wait_ev(1, t2);
		check(32'(t2 - t1), 32'(eff * CPM), "sample interval");
		$display("rate test done");
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		reg_test();
		relay_test();
		loc_test();
		func_test();
		cal_test();
		rate_test(7'h05, 7'h0a);
		rate_test(7'h32, 7'h32);
		rate_test(7'h7f, 7'h64);
		test_done();
	end
endmodule // testbench
